// ==== verilog/ssc_pkg.sv ====
`default_nettype none
package ssc_pkg;
  // ==========================================
  // register map
  localparam logic [31:0] SYSTEM_STATUS_ADDR = 32'h4980001c;
  localparam logic [31:0] SYSTEM_CONTROL_ADDR = 32'h49800020;
  localparam logic [31:0] SYSTEM_STATUS_RESET = 32'h00000000;
  localparam logic [31:0] SYSTEM_CONTROL_RESET = 32'h00000000;
  // ==========================================
  // status bit positions
  localparam int BYTE_ALIGN_FAULT_BIT = 15;
  localparam int TIMEOUT_FAULT_BIT = 14;
  localparam int BIT_STUFF_FAULT_BIT = 13;
  localparam int TOKEN_CRC_FAULT_BIT = 12;
  localparam int DATA_CRC_FAULT_BIT = 11;
  localparam int ELASTIC_OVERRUN_FAULT_BIT = 10;
  localparam int TOGGLE_MISMATCH_FLAG_BIT = 7;
  localparam int LINE_PLUS_LEVEL_BIT = 6;
  localparam int LINE_MINUS_LEVEL_BIT = 5;
  localparam int HOST_SPEED_FLAG_BIT = 4;
  localparam int SPEED_DETECT_DONE_BIT = 3;
  localparam int HOST_RESUME_FLAG_BIT = 2;
  localparam int HOST_SUSPEND_FLAG_BIT = 1;
  localparam int HOST_RESET_FLAG_BIT = 0;
  // clearable flags, error flags
  localparam logic [15:0] STATUS_CLEAR_MASK = 16'hfc8f;
  localparam logic [15:0] ERROR_FLAG_MASK = 16'hfc80;
  // ==========================================
  // control bit positions
  localparam int DMA_COUNT_ZERO_IRQ_EN_BIT = 14;
  localparam int DUAL_IRQ_EN_BIT = 12;
  localparam int ERROR_IRQ_EN_BIT = 8;
  localparam int SPEED_CTRL_ENABLE_BIT = 7;
  localparam int SPEED_END_IRQ_EN_BIT = 6;
  localparam int SPEED_LOGIC_HOLD_BIT = 3;
  localparam int SOFTWARE_RESUME_BIT = 2;
  localparam int SUSPEND_RESPONSE_EN_BIT = 1;
  localparam int RESET_RESPONSE_EN_BIT = 0;
  // writable control bits; bit 4 held at zero
  localparam logic [31:0] CONTROL_WRITE_MASK = 32'h000051cf;
  // ==========================================
  // software end commands and states
  typedef enum logic [1:0] {
    SSC_OP_READ_STATUS = 2'b00,
    SSC_OP_READ_CONTROL = 2'b01,
    SSC_OP_WRITE_CONTROL = 2'b10,
    SSC_OP_CLEAR_STATUS = 2'b11
  } ssc_op_t;
  typedef enum logic [1:0] {
    SSC_ST_IDLE = 2'b00,
    SSC_ST_READ = 2'b01,
    SSC_ST_WRITE = 2'b10,
    SSC_ST_DONE = 2'b11
  } ssc_state_t;
endpackage
`default_nettype wire

// ==== verilog/ssc_reg_if.sv ====
`default_nettype none
interface ssc_reg_if;
  logic sel;
  logic wr;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic ack;
  modport device (input sel, input wr, input addr, input wdata,
                  output rdata, output ack);
  modport software (output sel, output wr, output addr, output wdata,
                    input rdata, input ack);
endinterface
`default_nettype wire

// ==== verilog/ssc_device.sv ====
// Summary of operation
// - non-line flags interrupt; write one clears
// - byte alignment fault sets bit 15
// - timeout fault sets bit 14
// - bit stuff fault sets bit 13
// - token crc fault sets bit 12
// - data crc fault sets bit 11
// - elastic overrun sets bit 10
// - toggle mismatch sets bit 7
// - line levels bits 6,5; speed bit 4
// - speed detection end sets bit 3
// - host resume while suspended sets bit 2
// - host suspend sets bit 1
// - host reset sets bit 0
// - control bit 14 enables dma zero interrupt
// - dual enable holds interrupt until cleared
// - control bit 8 gates error flags
// - control bit 7 enables speed detection
// - control bit 6 enables speed end interrupt
// - control bit 3 holds speed detection
// - bit 2 drives resume while suspended
// - suspend acted on only with bit 1
// - reset acted on only with bit 0
`default_nettype none
module ssc_device (
  input wire logic mclk_in,
  input wire logic nrst_in,
  ssc_reg_if.device bus,
  input wire logic byte_align_err_in,
  input wire logic timeout_err_in,
  input wire logic bit_stuff_err_in,
  input wire logic token_crc_err_in,
  input wire logic data_crc_err_in,
  input wire logic elastic_overrun_in,
  input wire logic toggle_mismatch_in,
  input wire logic line_plus_in,
  input wire logic line_minus_in,
  input wire logic high_speed_in,
  input wire logic speed_detect_end_in,
  input wire logic host_resume_in,
  input wire logic host_suspend_in,
  input wire logic host_reset_in,
  input wire logic suspended_in,
  input wire logic dma_count_zero_in,
  output logic irq_out,
  output logic speed_detect_run_out,
  output logic resume_drive_out,
  output logic suspend_accept_out,
  output logic reset_accept_out
);
  // ==========================================
  // registers
  logic [15:0] flags;
  logic [31:0] control;
  logic [31:0] rdata;
  logic ack;
  logic irq_prev;
  logic [2:0] line_state;
  // ==========================================
  // decode
  wire status_hit = bus.addr == ssc_pkg::SYSTEM_STATUS_ADDR;
  wire control_hit = bus.addr == ssc_pkg::SYSTEM_CONTROL_ADDR;
  wire wr_status = bus.sel & bus.wr & status_hit;
  wire wr_control = bus.sel & bus.wr & control_hit;
  wire error_en = control[ssc_pkg::ERROR_IRQ_EN_BIT];
  wire speed_run = control[ssc_pkg::SPEED_CTRL_ENABLE_BIT] &
                   ~control[ssc_pkg::SPEED_LOGIC_HOLD_BIT];
  wire suspend_en = control[ssc_pkg::SUSPEND_RESPONSE_EN_BIT];
  wire reset_en = control[ssc_pkg::RESET_RESPONSE_EN_BIT];
  // ==========================================
  // enables
  wire speed_end_en = control[ssc_pkg::SPEED_END_IRQ_EN_BIT];
  wire dma_zero_en = control[ssc_pkg::DMA_COUNT_ZERO_IRQ_EN_BIT];
  wire resume_req = control[ssc_pkg::SOFTWARE_RESUME_BIT];
  // ==========================================
  // event sources
  wire [15:0] raw_err = {byte_align_err_in,
                         timeout_err_in,
                         bit_stuff_err_in,
                         token_crc_err_in,
                         data_crc_err_in,
                         elastic_overrun_in,
                         2'b00,
                         toggle_mismatch_in,
                         7'h00};
  wire [15:0] raw_host = {12'h000,
                          speed_detect_end_in & speed_run,
                          host_resume_in & suspended_in,
                          host_suspend_in & suspend_en,
                          host_reset_in & reset_en};
  // ==========================================
  // per-bit set and clear
  logic [15:0] set_flags;
  logic [15:0] clr_flags;
  logic [15:0] next_flags;
  genvar b;
  for (b = 0; b < 16; b++) begin : g_flag
    // error events count only with the error enable
    assign set_flags[b] = ssc_pkg::STATUS_CLEAR_MASK[b] &
                          (raw_err[b] & error_en | raw_host[b]);
    // write one clears
    assign clr_flags[b] = ssc_pkg::STATUS_CLEAR_MASK[b] & wr_status &
                          bus.wdata[b];
    // a set in the same cycle beats the clear
    assign next_flags[b] = set_flags[b] | (flags[b] & ~clr_flags[b]);
  end
  // ==========================================
  // interrupt
  wire [15:0] irq_mask = {ssc_pkg::ERROR_FLAG_MASK[15:8] & {8{error_en}},
                          ssc_pkg::ERROR_FLAG_MASK[7] & error_en,
                          3'b000,
                          speed_end_en,
                          3'b111};
  wire dma_irq = dma_count_zero_in &
                 dma_zero_en;
  wire irq_level = |(flags & irq_mask) | dma_irq;
  wire dual_en = control[ssc_pkg::DUAL_IRQ_EN_BIT];
  wire next_irq = dual_en ? irq_level : irq_level & ~irq_prev;
  // ==========================================
  // read data
  wire [31:0] status_view = {16'h0000,
                             flags[15:7],
                             line_state,
                             flags[3:0]};
  wire [31:0] read_view = status_hit ? status_view :
                          control_hit ? control : 32'h00000000;
  // hold the last answer between requests
  wire [31:0] next_rdata = bus.sel ? read_view : rdata;
  // ==========================================
  // status flags
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      flags <= ssc_pkg::SYSTEM_STATUS_RESET[15:0];
    end else begin
      flags <= next_flags;
    end
  end
  // ==========================================
  // control register
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      control <= ssc_pkg::SYSTEM_CONTROL_RESET;
    end else if (wr_control) begin
      control <= bus.wdata & ssc_pkg::CONTROL_WRITE_MASK;
    end
  end
  // ==========================================
  // line levels, one edge late
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      line_state <= 3'b000;
    end else begin
      line_state <= {line_plus_in, line_minus_in, high_speed_in};
    end
  end
  // ==========================================
  // interrupt level history
  // last level, for the pulse mode
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_prev <= 1'b0;
    end else begin
      irq_prev <= irq_level;
    end
  end
  // ==========================================
  // interrupt output
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= next_irq;
    end
  end
  // ==========================================
  // read data register
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata <= 32'h00000000;
    end else begin
      rdata <= next_rdata;
    end
  end
  // ==========================================
  // acknowledge
  // one answer for every request cycle
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ack <= 1'b0;
    end else begin
      ack <= bus.sel;
    end
  end
  // ==========================================
  // outputs
  assign bus.rdata = rdata;
  assign bus.ack = ack;
  assign speed_detect_run_out = speed_run;
  // resume only while the core is suspended
  assign resume_drive_out = resume_req &
                            suspended_in;
  // host signalling passes only when enabled
  assign suspend_accept_out = host_suspend_in & suspend_en;
  assign reset_accept_out = host_reset_in & reset_en;
endmodule
`default_nettype wire

// ==== verilog/ssc_software.sv ====
`default_nettype none
module ssc_software (
  input wire logic mclk_in,
  input wire logic nrst_in,
  ssc_reg_if.software bus,
  input wire logic cmd_valid_in,
  input wire logic [1:0] cmd_op_in,
  input wire logic [31:0] cmd_data_in,
  output logic cmd_ready_out,
  output logic done_out,
  output logic [31:0] result_out
);
  // ==========================================
  // state
  ssc_pkg::ssc_state_t state;
  ssc_pkg::ssc_state_t next_state;
  logic [1:0] op;
  logic [31:0] data;
  logic [31:0] result;
  logic done;
  // ==========================================
  // decode
  wire is_status = op == ssc_pkg::SSC_OP_READ_STATUS ||
                   op == ssc_pkg::SSC_OP_CLEAR_STATUS;
  wire is_write = op == ssc_pkg::SSC_OP_WRITE_CONTROL;
  wire is_clear = op == ssc_pkg::SSC_OP_CLEAR_STATUS;
  // only flags seen set are written back as ones
  wire [31:0] clear_word = data & bus.rdata &
                           {16'h0000, ssc_pkg::STATUS_CLEAR_MASK};
  // enables and hold bits pass as given
  wire [31:0] control_word = data &
                             ssc_pkg::CONTROL_WRITE_MASK;
  assign cmd_ready_out = state == ssc_pkg::SSC_ST_IDLE;
  assign bus.sel = state == ssc_pkg::SSC_ST_READ ||
                   state == ssc_pkg::SSC_ST_WRITE;
  assign bus.wr = state == ssc_pkg::SSC_ST_WRITE;
  assign bus.addr = is_status ? ssc_pkg::SYSTEM_STATUS_ADDR :
                    ssc_pkg::SYSTEM_CONTROL_ADDR;
  assign bus.wdata = data;
  assign done_out = done;
  assign result_out = result;
  always_comb begin
    next_state = state;
    case (state)
      ssc_pkg::SSC_ST_IDLE: begin
        if (cmd_valid_in) begin
          next_state = cmd_op_in == ssc_pkg::SSC_OP_WRITE_CONTROL ?
                       ssc_pkg::SSC_ST_WRITE : ssc_pkg::SSC_ST_READ;
        end
      end
      ssc_pkg::SSC_ST_READ: begin
        if (bus.ack) begin
          next_state = is_clear ? ssc_pkg::SSC_ST_WRITE :
                       ssc_pkg::SSC_ST_DONE;
        end
      end
      ssc_pkg::SSC_ST_WRITE: begin
        if (bus.ack) begin
          next_state = ssc_pkg::SSC_ST_DONE;
        end
      end
      ssc_pkg::SSC_ST_DONE: begin
        next_state = ssc_pkg::SSC_ST_IDLE;
      end
      default: begin
        next_state = ssc_pkg::SSC_ST_IDLE;
      end
    endcase
  end
  // ==========================================
  // flops
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= ssc_pkg::SSC_ST_IDLE;
      op <= 2'b00;
      data <= 32'h00000000;
      result <= 32'h00000000;
      done <= 1'b0;
    end else begin
      state <= next_state;
      done <= next_state == ssc_pkg::SSC_ST_DONE;
      if (state == ssc_pkg::SSC_ST_IDLE && cmd_valid_in) begin
        op <= cmd_op_in;
        data <= cmd_op_in == ssc_pkg::SSC_OP_WRITE_CONTROL ?
                cmd_data_in : cmd_data_in;
      end
      if (state == ssc_pkg::SSC_ST_IDLE && cmd_valid_in &&
          cmd_op_in == ssc_pkg::SSC_OP_WRITE_CONTROL) begin
        data <= cmd_data_in & ssc_pkg::CONTROL_WRITE_MASK;
      end
      if (state == ssc_pkg::SSC_ST_READ && bus.ack) begin
        result <= bus.rdata;
        if (is_clear) begin
          data <= clear_word;
        end
      end
      if (state == ssc_pkg::SSC_ST_WRITE && bus.ack && is_write) begin
        result <= control_word;
      end
    end
  end
endmodule
`default_nettype wire

// ==== test/ssc_reg_asserts.sv ====
`default_nettype none
module ssc_reg_asserts (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic sel,
  input wire logic wr,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic ack
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // decode and control shadow
  wire logic st_a = addr == ssc_pkg::SYSTEM_STATUS_ADDR;
  wire logic ct_a = addr == ssc_pkg::SYSTEM_CONTROL_ADDR;
  wire logic rd_st = sel && !wr && st_a;
  wire logic rd_ct = sel && !wr && ct_a;
  logic [31:0] shadow;
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      shadow <= 32'h0;
    end else if (sel && wr && ct_a) begin
      shadow <= wdata & ssc_pkg::CONTROL_WRITE_MASK;
    end
  end
  // ==========================================
  // properties
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  ack_follows_sel_a: assert property (
    sel |=> ack) else $error("ack missing after request");
  ack_only_after_a: assert property (
    ack |-> $past(sel)) else $error("ack without request");
  status_reserved_a: assert property (
    ack && $past(rd_st) |-> rdata[31:16] == 16'h0 && rdata[9:8] == 2'h0)
    else $error("status reserved bits set");
  control_mask_a: assert property (
    ack && $past(rd_ct) |-> (rdata & ~ssc_pkg::CONTROL_WRITE_MASK) == 32'h0)
    else $error("control reserved bits set");
  control_readback_a: assert property (
    ack && $past(rd_ct) |-> rdata == $past(shadow))
    else $error("control readback differs");
  rdata_hold_a: assert property (
    !sel |=> $stable(rdata)) else $error("read data moved while idle");
  write_target_a: assert property (
    sel && wr |-> st_a || ct_a) else $error("write to odd address");
  clear_after_read_a: assert property (
    sel && wr && st_a |-> $past(rd_st)) else $error("clear without read");
  cover property (sel && wr && st_a);
  cover property (sel && wr && ct_a);
  cover property (ack && $past(rd_st) && rdata != 32'h0);
endmodule
`default_nettype wire

// ==== test/usb_device_system_status_control_test.sv ====
`default_nettype none
module usb_device_system_status_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [10:0] ev = 11'h0;
  logic lp = 1'b0, lm = 1'b0, hs = 1'b0, susp = 1'b0, dz = 1'b0, cv = 1'b0;
  logic [1:0] cop = 2'h0;
  logic [31:0] cdat = 32'h0, res;
  wire logic irq, run, rdrv, sacc, racc, crdy, done;
  wire logic [31:0] rslt;
  int err_total = 0, num_checks = 0, cycles = 0, n;
  int eb[7] = '{15, 14, 13, 12, 11, 10, 7};
  ssc_reg_if bus_if ();
  ssc_device ssc_device_inst (.mclk_in(mclk_in), .nrst_in(nrst_in),
    .bus(bus_if.device), .byte_align_err_in(ev[0]), .timeout_err_in(ev[1]),
    .bit_stuff_err_in(ev[2]), .token_crc_err_in(ev[3]),
    .data_crc_err_in(ev[4]), .elastic_overrun_in(ev[5]),
    .toggle_mismatch_in(ev[6]), .line_plus_in(lp), .line_minus_in(lm),
    .high_speed_in(hs), .speed_detect_end_in(ev[7]), .host_resume_in(ev[8]),
    .host_suspend_in(ev[9]), .host_reset_in(ev[10]), .suspended_in(susp),
    .dma_count_zero_in(dz), .irq_out(irq), .speed_detect_run_out(run),
    .resume_drive_out(rdrv), .suspend_accept_out(sacc),
    .reset_accept_out(racc));
  ssc_software ssc_software_inst (.mclk_in(mclk_in), .nrst_in(nrst_in),
    .bus(bus_if.software), .cmd_valid_in(cv), .cmd_op_in(cop),
    .cmd_data_in(cdat), .cmd_ready_out(crdy), .done_out(done),
    .result_out(rslt));
  ssc_reg_asserts ssc_reg_asserts_inst (.mclk_in(mclk_in), .nrst_in(nrst_in),
    .sel(bus_if.sel), .wr(bus_if.wr), .addr(bus_if.addr),
    .wdata(bus_if.wdata), .rdata(bus_if.rdata), .ack(bus_if.ack));
  // ==========================================
  // clock, timeout, verdict
  initial forever #4 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ==========================================
  // compares and command tasks
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [1:0] op, input logic [31:0] d);
    int k = 0;
    check_bit(crdy, 1'b1);
    cv = 1'b1;
    cop = op;
    cdat = d;
    @(posedge mclk_in);
    #1 cv = 1'b0;
    check_bit(crdy, 1'b0);
    while (done !== 1'b1 && k < 20) begin
      @(posedge mclk_in);
      #1 k++;
    end
    check_bit(done, 1'b1);
    res = rslt;
    @(posedge mclk_in);
    #1;
  endtask
  task automatic rd_st(input logic [31:0] exp);
    cmd(ssc_pkg::SSC_OP_READ_STATUS, 32'h0);
    check_word(res, exp);
  endtask
  task automatic rd_ct(input logic [31:0] exp);
    cmd(ssc_pkg::SSC_OP_READ_CONTROL, 32'h0);
    check_word(res, exp);
  endtask
  task automatic wctl(input logic [31:0] d);
    cmd(ssc_pkg::SSC_OP_WRITE_CONTROL, d);
  endtask
  task automatic clr(input logic [31:0] m);
    cmd(ssc_pkg::SSC_OP_CLEAR_STATUS, m);
  endtask
  task automatic pulse(input int i);
    ev[i] = 1'b1;
    @(posedge mclk_in);
    #1 ev[i] = 1'b0;
  endtask
  // ==========================================
  // sequence
  initial begin
    repeat (4) @(posedge mclk_in);
    #1 nrst_in = 1'b1;
    rd_st(32'h0);
    rd_ct(32'h0);
    for (int i = 0; i < 7; i++) pulse(i);
    rd_st(32'h0);
    check_bit(irq, 1'b0);
    wctl(32'h1100);
    for (int i = 0; i < 7; i++) begin
      pulse(i);
      rd_st(32'h1 << eb[i]);
      check_bit(irq, 1'b1);
      clr(32'hffff);
      rd_st(32'h0);
      check_bit(irq, 1'b0);
    end
    wctl(32'h100);
    pulse(0);
    n = 0;
    repeat (5) begin
      @(posedge mclk_in);
      #1 if (irq === 1'b1) n++;
    end
    check_word(n, 32'h1);
    clr(32'hffff);
    lp = 1'b1;
    hs = 1'b1;
    rd_st(32'h50);
    clr(32'hffff);
    rd_st(32'h50);
    lp = 1'b0;
    lm = 1'b1;
    hs = 1'b0;
    rd_st(32'h20);
    lm = 1'b0;
    wctl(32'h10c8);
    check_bit(run, 1'b0);
    pulse(7);
    rd_st(32'h0);
    wctl(32'h10c0);
    check_bit(run, 1'b1);
    pulse(7);
    rd_st(32'h8);
    check_bit(irq, 1'b1);
    clr(32'h8);
    wctl(32'h1080);
    pulse(7);
    rd_st(32'h8);
    check_bit(irq, 1'b0);
    clr(32'h8);
    wctl(32'h1000);
    for (int i = 8; i < 11; i++) pulse(i);
    rd_st(32'h0);
    wctl(32'h1003);
    ev[10:9] = 2'h3;
    @(negedge mclk_in);
    check_bit(sacc, 1'b1);
    check_bit(racc, 1'b1);
    @(posedge mclk_in);
    #1 ev[10:9] = 2'h0;
    rd_st(32'h3);
    check_bit(irq, 1'b1);
    clr(32'h3);
    susp = 1'b1;
    pulse(8);
    rd_st(32'h4);
    clr(32'h4);
    check_bit(rdrv, 1'b0);
    wctl(32'h1004);
    check_bit(rdrv, 1'b1);
    susp = 1'b0;
    rd_ct(32'h1004);
    check_bit(rdrv, 1'b0);
    dz = 1'b1;
    wctl(32'h1000);
    check_bit(irq, 1'b0);
    wctl(32'h5000);
    check_bit(irq, 1'b1);
    dz = 1'b0;
    wctl(32'hffffffff);
    rd_ct(32'h51cf);
    pulse(0);
    rd_st(32'h8000);
    nrst_in = 1'b0;
    @(posedge mclk_in);
    #1 nrst_in = 1'b1;
    check_bit(irq, 1'b0);
    rd_st(32'h0);
    rd_ct(32'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
